//--- design/lcs_defines.vh
// Register offsets, field positions, reset values and timing constants of the charge controller.
`ifndef LCS_DEFINES_VH
`define LCS_DEFINES_VH

`define LCS_ADDR_CTRL        12'h000
`define LCS_ADDR_STATUS      12'h004
`define LCS_ADDR_IRQ_STATUS  12'h008
`define LCS_ADDR_IRQ_MASK    12'h00C
`define LCS_ADDR_ISET        12'h010

`define LCS_CTRL_SUSPEND     0
`define LCS_CTRL_TSEL_LO     1
`define LCS_CTRL_TSEL_HI     2
`define LCS_CTRL_LEVEL       3
`define LCS_CTRL_LEVEL_USE   4
`define LCS_CTRL_RESET       32'h0000_0000

`define LCS_TSEL_60          2'h0
`define LCS_TSEL_90          2'h1
`define LCS_TSEL_120         2'h2
`define LCS_TSEL_OFF         2'h3

`define LCS_TIMER_60_MIN     8'h3C
`define LCS_TIMER_90_MIN     8'h5A
`define LCS_TIMER_120_MIN    8'h78
`define LCS_EOC_MIN          8'h04

`define LCS_PRE_MIN_MA       10'h02D
`define LCS_ISET1_RESET      10'h05A
`define LCS_ISET2_RESET      10'h1C2

`define LCS_CLK_MHZ          125
`define LCS_MINUTE_S         60

`define LCS_IRQ_W            5
`define LCS_IRQ_FAULT        0
`define LCS_IRQ_DONE         1
`define LCS_IRQ_SUSPEND      2
`define LCS_IRQ_START        3
`define LCS_IRQ_RESTART      4

`endif

//--- design/lcs_sync.v
// Two-flop synchroniser bank for asynchronous inputs.
module lcs_sync #(
    parameter W = 1
) (
    input  wire         core_clk,
    input  wire         reset,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] stage1;

    // First stage is read only by the second stage.
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            stage1   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // lcs_sync

//--- design/lcs_minute_tick.v
// Divider that produces a one-cycle pulse once per minute.
module lcs_minute_tick #(
    parameter TICK_CYCLES = 64'd7500000000
) (
    input  wire core_clk,
    input  wire reset,
    output reg  tick
);
    reg [63:0] count;

    // Free-running count; shortened in simulation via the parameter.
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            count <= 64'h0000_0000_0000_0000;
            tick  <= 1'b0;
        end
        else if (count >= TICK_CYCLES - 64'd1)
        begin
            count <= 64'h0000_0000_0000_0000;
            tick  <= 1'b1;
        end
        else
        begin
            count <= count + 64'd1;
            tick  <= 1'b0;
        end
    end
endmodule // lcs_minute_tick

//--- design/lcs_charger.v
// Charge control state machine with APB registers and interrupt.
// Functional notes
// - Input removed, under UVLO, or below battery forces suspend.
// - Each cycle starts in precondition at max of 45mA and 10% fast current.
// - Precondition moves to fast-charge when precondition threshold reached.
// - Precondition timer expiry moves to timeout-fault.
// - Fast-charge is constant current; termination voltage moves to top-off.
// - Top-off is constant voltage; EOC held 4 minutes moves to sleep.
// - Sleep isolates battery, restarts cycle after about 200mV drop.
// - Suspend isolates battery; leaving it clears timer and enters precondition.
// - Timeout-fault stops charging, sets fault flag, isolates battery.
// - Timeout-fault returns to charging only through suspend.
// - Charging flag and indicator sink in precondition, fast-charge, top-off.
// - Safety timer 60 minutes default, 90, 120 or disabled selectable.
// - Cycle auto-starts unless level input floats, suspend bit set, or fault.
//
// Local design decisions: the APB slave port and the address map.
`include "lcs_defines.vh"
module lcs_charger #(
    parameter MINUTE_CYCLES = 64'd7500000000
) (
    input  wire        core_clk,
    input  wire        reset,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        supply_valid,
    input  wire        precond_reached,
    input  wire        term_reached,
    input  wire        eoc_current,
    input  wire        restart_drop,
    input  wire        level_high,
    input  wire        level_floating,
    output reg         charge_enable,
    output reg         cc_mode,
    output reg         cv_mode,
    output reg         battery_hiz,
    output reg  [9:0]  current_cmd,
    output reg         charge_indicator_output_o,
    output reg         charge_indicator_output_oe_n,
    output reg         irq
);
    // One-hot states.
    localparam [5:0] ST_PRE  = 6'b000001;
    localparam [5:0] ST_FAST = 6'b000010;
    localparam [5:0] ST_TOP  = 6'b000100;
    localparam [5:0] ST_SLP  = 6'b001000;
    localparam [5:0] ST_SUS  = 6'b010000;
    localparam [5:0] ST_FLT  = 6'b100000;

    wire [6:0] sync_in;
    wire       s_valid   = sync_in[0];
    wire       s_pre     = sync_in[1];
    wire       s_term    = sync_in[2];
    wire       s_eoc     = sync_in[3];
    wire       s_drop    = sync_in[4];
    wire       s_lvl     = sync_in[5];
    wire       s_float   = sync_in[6];
    wire       tick;

    reg  [5:0]  state;
    reg  [5:0]  next_state;
    reg  [31:0] ctrl;
    reg  [9:0]  iset1;
    reg  [9:0]  iset2;
    reg  [`LCS_IRQ_W-1:0] irq_status;
    reg  [`LCS_IRQ_W-1:0] irq_mask;
    reg  [7:0]  safety_min;
    reg  [7:0]  eoc_min;
    reg         timeout_fault_flag;
    reg  [7:0]  timer_limit;
    reg  [9:0]  fast_current;
    reg  [9:0]  tenth;
    reg  [9:0]  next_cmd;
    reg  [`LCS_IRQ_W-1:0] events;

    wire [1:0] safety_timer_select = ctrl[`LCS_CTRL_TSEL_HI:`LCS_CTRL_TSEL_LO];
    wire       charge_suspend_bit  = ctrl[`LCS_CTRL_SUSPEND];
    wire       charging_active_flag = (state == ST_PRE) | (state == ST_FAST) | (state == ST_TOP);
    wire       start_ok = s_valid & ~s_float & ~charge_suspend_bit;
    wire       apb_wr = psel & penable & pwrite;
    wire       apb_rd = psel & penable & ~pwrite;
    wire       timer_expired = (safety_timer_select != `LCS_TSEL_OFF)
                             & (safety_min >= timer_limit);

    lcs_sync #(
        .W (7)
    ) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in ({level_floating, level_high, restart_drop, eoc_current,
                    term_reached, precond_reached, supply_valid}),
        .sync_out (sync_in)
    );

    lcs_minute_tick #(
        .TICK_CYCLES (MINUTE_CYCLES)
    ) u_tick (
        .core_clk (core_clk),
        .reset    (reset),
        .tick     (tick)
    );

    // Timer limit from the select field.
    always @*
    begin
        case (safety_timer_select)
            `LCS_TSEL_90:  timer_limit = `LCS_TIMER_90_MIN;
            `LCS_TSEL_120: timer_limit = `LCS_TIMER_120_MIN;
            default:       timer_limit = `LCS_TIMER_60_MIN;
        endcase
    end

    // Precondition current is the larger of the floor and a tenth of fast current.
    always @*
    begin
        if (ctrl[`LCS_CTRL_LEVEL_USE])
            fast_current = ctrl[`LCS_CTRL_LEVEL] ? iset2 : iset1;
        else
            fast_current = s_lvl ? iset2 : iset1;
        tenth = fast_current / 10'd10;
        if (tenth > `LCS_PRE_MIN_MA)
            next_cmd = tenth;
        else
            next_cmd = `LCS_PRE_MIN_MA;
    end

    // Next state. Loss of supply always wins, so any state falls to suspend.
    always @*
    begin
        next_state = state;
        if (!s_valid)
            next_state = ST_SUS;
        else
        begin
            case (state)
                ST_PRE:
                    if (charge_suspend_bit || s_float)
                        next_state = ST_SUS;
                    else if (s_pre)
                        next_state = ST_FAST;
                    else if (timer_expired)
                        next_state = ST_FLT;
                ST_FAST:
                    if (charge_suspend_bit || s_float)
                        next_state = ST_SUS;
                    else if (s_term)
                        next_state = ST_TOP;
                ST_TOP:
                    if (charge_suspend_bit || s_float)
                        next_state = ST_SUS;
                    else if (eoc_min >= `LCS_EOC_MIN)
                        next_state = ST_SLP;
                ST_SLP:
                    if (charge_suspend_bit || s_float)
                        next_state = ST_SUS;
                    else if (s_drop)
                        next_state = ST_PRE;
                ST_SUS:
                    if (start_ok)
                        next_state = ST_PRE;
                ST_FLT:
                    next_state = ST_FLT;
                default:
                    next_state = ST_SUS;
            endcase
        end
    end

    // Events that feed the sticky status bits.
    always @*
    begin
        events = {`LCS_IRQ_W{1'b0}};
        events[`LCS_IRQ_FAULT]   = (next_state == ST_FLT) & (state != ST_FLT);
        events[`LCS_IRQ_DONE]    = (next_state == ST_SLP) & (state != ST_SLP);
        events[`LCS_IRQ_SUSPEND] = (next_state == ST_SUS) & (state != ST_SUS);
        events[`LCS_IRQ_START]   = (next_state == ST_PRE) & (state == ST_SUS);
        events[`LCS_IRQ_RESTART] = (next_state == ST_PRE) & (state == ST_SLP);
    end

    // State, timers and fault flag. Fault is cleared when a new cycle starts.
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state              <= ST_SUS;
            safety_min         <= 8'h00;
            eoc_min            <= 8'h00;
            timeout_fault_flag <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (next_state != ST_PRE || state != ST_PRE)
                safety_min <= 8'h00;
            else if (tick && safety_min != 8'hFF)
                safety_min <= safety_min + 8'h01;
            if (state != ST_TOP || !s_eoc)
                eoc_min <= 8'h00;
            else if (tick && eoc_min != 8'hFF)
                eoc_min <= eoc_min + 8'h01;
            if (next_state == ST_FLT)
                timeout_fault_flag <= 1'b1;
            else if (state == ST_SUS && next_state == ST_PRE)
                timeout_fault_flag <= 1'b0;
        end
    end

    // Leave fault to suspend when supply drops; the fault flag does not gate restart, which clears it.
    // Supply loss from fault is handled by the branch above.

    // Drive outputs straight from flops.
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            charge_enable                <= 1'b0;
            cc_mode                      <= 1'b0;
            cv_mode                      <= 1'b0;
            battery_hiz                  <= 1'b1;
            current_cmd                  <= 10'h000;
            charge_indicator_output_o    <= 1'b0;
            charge_indicator_output_oe_n <= 1'b1;
        end
        else
        begin
            charge_enable <= (next_state == ST_PRE) | (next_state == ST_FAST)
                           | (next_state == ST_TOP);
            cc_mode       <= (next_state == ST_FAST);
            cv_mode       <= (next_state == ST_TOP);
            battery_hiz   <= (next_state == ST_SLP) | (next_state == ST_SUS)
                           | (next_state == ST_FLT);
            if (next_state == ST_PRE)
                current_cmd <= next_cmd;
            else if (next_state == ST_FAST || next_state == ST_TOP)
                current_cmd <= fast_current;
            else
                current_cmd <= 10'h000;
            charge_indicator_output_o    <= 1'b0;
            charge_indicator_output_oe_n <= ~((next_state == ST_PRE) | (next_state == ST_FAST)
                                           | (next_state == ST_TOP));
        end
    end

    // APB slave: zero wait states, unmapped addresses return pslverr.
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl       <= `LCS_CTRL_RESET;
            iset1      <= `LCS_ISET1_RESET;
            iset2      <= `LCS_ISET2_RESET;
            irq_mask   <= {`LCS_IRQ_W{1'b0}};
            irq_status <= {`LCS_IRQ_W{1'b0}};
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            irq        <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (apb_wr && pready)
            begin
                case (paddr)
                    `LCS_ADDR_CTRL:     ctrl <= {27'h000_0000, pwdata[4:0]};
                    `LCS_ADDR_IRQ_MASK: irq_mask <= pwdata[`LCS_IRQ_W-1:0];
                    `LCS_ADDR_ISET:
                    begin
                        iset1 <= pwdata[9:0];
                        iset2 <= pwdata[25:16];
                    end
                    default: ;
                endcase
            end
            // Read clears status, but an event in the same cycle survives.
            if (apb_rd && pready && paddr == `LCS_ADDR_IRQ_STATUS)
                irq_status <= events;
            else
                irq_status <= irq_status | events;
            if (psel && !penable)
            begin
                case (paddr)
                    `LCS_ADDR_CTRL:       prdata <= ctrl;
                    `LCS_ADDR_STATUS:     prdata <= {20'h0_0000, 2'b00, state,
                                                     2'b00, timeout_fault_flag,
                                                     charging_active_flag};
                    `LCS_ADDR_IRQ_STATUS: prdata <= {27'h000_0000, irq_status};
                    `LCS_ADDR_IRQ_MASK:   prdata <= {27'h000_0000, irq_mask};
                    `LCS_ADDR_ISET:       prdata <= {6'h00, iset2, 6'h00, iset1};
                    default:
                    begin
                        prdata  <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
            irq <= |((irq_status | events) & irq_mask);
        end
    end
endmodule // lcs_charger

//--- verif/lcs_chk.sv
// Concurrent checks on the charge controller pins and APB answer.
module lcs_chk (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       supply_valid,
    input wire logic       charge_enable,
    input wire logic       cc_mode,
    input wire logic       cv_mode,
    input wire logic       battery_hiz,
    input wire logic [9:0] current_cmd,
    input wire logic       charge_indicator_output_o,
    input wire logic       charge_indicator_output_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Supply held low long enough to cross the two-flop synchroniser.
    sequence s_supply_gone;
        !supply_valid [*5];
    endsequence
    sequence s_setup;
        psel && !penable;
    endsequence
    a_supply_suspend: assert property (s_supply_gone |-> ##1 (battery_hiz && !charge_enable))
        else $error("Supply loss did not isolate the battery.");
    a_precond_entry: assert property ($rose(charge_enable) |-> !cc_mode && !cv_mode && current_cmd >= 10'h02D)
        else $error("Charging did not start in precondition.");
    a_fast_from_pre: assert property ($rose(cc_mode) |-> $past(charge_enable) && !cv_mode)
        else $error("Fast charge entered from a non-charging state.");
    a_top_from_fast: assert property ($rose(cv_mode) |-> $past(cc_mode))
        else $error("Top-off entered without fast charge.");
    a_mode_excl: assert property ((cc_mode || cv_mode) |-> charge_enable && !(cc_mode && cv_mode))
        else $error("Regulation modes overlap.");
    a_hiz_excl: assert property (battery_hiz == !charge_enable)
        else $error("Battery isolation disagrees with charging.");
    a_idle_cmd: assert property (!charge_enable |-> current_cmd == 10'h000)
        else $error("Current commanded while not charging.");
    a_ind_follow: assert property (charge_indicator_output_oe_n == !charge_enable && !charge_indicator_output_o)
        else $error("Indicator does not follow charging.");
    a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
        else $error("APB answer not a single cycle after setup.");
    a_err_pulse: assert property (pslverr |-> pready)
        else $error("Error flag without ready.");
endmodule // lcs_chk

//--- verif/lcs_cell_model.sv
// Behavioural cell and comparator model on the sense side of the controller.
module lcs_cell_model (
    input  wire logic       core_clk,
    input  wire logic       vin_ok,
    input  wire logic       dead,
    input  wire logic       leak,
    input  wire logic       cell_reset,
    input  wire logic       charge_enable,
    input  wire logic       cv_mode,
    input  wire logic       battery_hiz,
    input  wire logic [9:0] current_cmd,
    output logic            supply_valid,
    output logic            precond_reached,
    output logic            term_reached,
    output logic            eoc_current,
    output logic            restart_drop
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PRE_MV = 3000;
    localparam int TERM_MV = 4200;
    int cell_mv = 2990;
    int peak_mv = 0;
    int step;
    assign step = int'(current_cmd) / 45;
    // A dead cell never rises, so only the safety timer or a suspend takes it out of precondition.
    always @(posedge core_clk)
    begin
        if (cell_reset)
            cell_mv <= 2990;
        else if (charge_enable && !dead)
            cell_mv <= (cell_mv + step > TERM_MV) ? TERM_MV : cell_mv + step;
        else if (battery_hiz && leak)
            cell_mv <= cell_mv - 1;
        if (cv_mode)
            peak_mv <= cell_mv;
    end
    // Comparator outputs; the full cell draws almost no current in top-off.
    assign supply_valid = vin_ok;
    assign precond_reached = cell_mv >= PRE_MV;
    assign term_reached = cell_mv >= TERM_MV;
    assign eoc_current = cv_mode && cell_mv >= TERM_MV;
    assign restart_drop = peak_mv - cell_mv >= 200;
endmodule // lcs_cell_model

//--- verif/li_ion_charge_state_machine_tb_top.sv
// Self-checking bench for the charge controller.
`include "lcs_defines.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); fail_count++; end end
module li_ion_charge_state_machine_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MIN = 20;
    typedef struct {bit wr; logic [11:0] a; logic [31:0] d; logic [31:0] e; bit err;} lcs_row_t;
    lcs_row_t rows [7] = '{
        '{0, `LCS_ADDR_CTRL, 32'h0000_0000, 32'h0000_0000, 0},
        '{0, `LCS_ADDR_STATUS, 32'h0000_0000, 32'h0000_0100, 0},
        '{0, `LCS_ADDR_IRQ_MASK, 32'h0000_0000, 32'h0000_0000, 0},
        '{0, `LCS_ADDR_ISET, 32'h0000_0000, 32'h01C2_005A, 0},
        '{0, 12'h014, 32'h0000_0000, 32'h0000_0000, 1},
        '{1, `LCS_ADDR_IRQ_MASK, 32'h0000_001F, 32'h0000_0000, 0},
        '{0, `LCS_ADDR_IRQ_MASK, 32'h0000_0000, 32'h0000_001F, 0}};
    int mins [3] = '{60, 90, 120};
    logic        core_clk, reset, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic        level_floating, level_high, vin_ok, dead, leak, cell_reset;
    wire  [31:0] prdata;
    wire         pready, pslverr, supply_valid, precond_reached, term_reached;
    wire         eoc_current, restart_drop, charge_enable, cc_mode, cv_mode, battery_hiz;
    wire  [9:0]  current_cmd;
    wire         ind_o, ind_oe_n, irq;
    wire  [3:0]  obs = {battery_hiz, cv_mode, cc_mode, charge_enable};
    wire         ind_pin = ind_oe_n ? 1'b1 : ind_o;
    int          fail_count, checks, cyc, t0;
    lcs_charger #(.MINUTE_CYCLES(64'd20)) uut (
        .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_valid(supply_valid), .precond_reached(precond_reached),
        .term_reached(term_reached), .eoc_current(eoc_current), .restart_drop(restart_drop),
        .level_high(level_high), .level_floating(level_floating), .charge_enable(charge_enable),
        .cc_mode(cc_mode), .cv_mode(cv_mode), .battery_hiz(battery_hiz),
        .current_cmd(current_cmd), .charge_indicator_output_o(ind_o),
        .charge_indicator_output_oe_n(ind_oe_n), .irq(irq));
    lcs_cell_model u_cell (
        .core_clk(core_clk), .vin_ok(vin_ok), .dead(dead), .leak(leak),
        .cell_reset(cell_reset), .charge_enable(charge_enable), .cv_mode(cv_mode),
        .battery_hiz(battery_hiz), .current_cmd(current_cmd), .supply_valid(supply_valid),
        .precond_reached(precond_reached), .term_reached(term_reached),
        .eoc_current(eoc_current), .restart_drop(restart_drop));
    // Free-running core clock at 125 MHz and a cycle counter for timing checks.
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 16)
        begin
            fail_count++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    // Bounded wait for one pin of obs to reach a level.
    task automatic wait_obs(input int b, input logic v, input int bound);
        int n;
        n = 0;
        while (obs[b] !== v && n < bound)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n >= bound)
        begin
            fail_count++;
            final_report();
        end
    endtask
    task automatic status(input logic [31:0] e);
        apb(0, `LCS_ADDR_STATUS, 32'h0000_0000);
        `CHK(rd, e)
    endtask
    initial
    begin
        {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        {level_floating, level_high, vin_ok, dead, leak, cell_reset} = 6'h00;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) `CHK(rd, rows[i].e)
            `CHK(err, rows[i].err)
        end
        `CHK(ind_pin, 1'b1)
        $display("Register rows done");
        vin_ok <= 1'b1;
        wait_obs(0, 1, 40);
        `CHK(current_cmd, 10'h02D)
        status(32'h0000_0011);
        `CHK(ind_pin, 1'b0)
        wait_obs(1, 1, 200);
        `CHK(current_cmd, 10'h05A)
        wait_obs(2, 1, 2000);
        t0 = cyc;
        status(32'h0000_0041);
        wait_obs(3, 1, 10 * MIN);
        `CHK(cyc - t0 > 3 * MIN && cyc - t0 <= 5 * MIN + 8, 1'b1)
        status(32'h0000_0080);
        `CHK(irq, 1'b1)
        apb(0, `LCS_ADDR_IRQ_STATUS, 32'h0000_0000);
        `CHK(rd[1], 1'b1)
        apb(0, `LCS_ADDR_IRQ_STATUS, 32'h0000_0000);
        `CHK({rd, irq}, 33'h0_0000_0000)
        $display("Charge cycle done");
        apb(1, `LCS_ADDR_ISET, 32'h0258_005A);
        apb(1, `LCS_ADDR_CTRL, 32'h0000_0018);
        apb(1, `LCS_ADDR_IRQ_MASK, 32'h0000_0000);
        leak <= 1'b1;
        wait_obs(0, 1, 400);
        leak <= 1'b0;
        `CHK(current_cmd, 10'h03C)
        wait_obs(1, 1, 40);
        `CHK(current_cmd, 10'h258)
        `CHK(irq, 1'b0)
        apb(1, `LCS_ADDR_IRQ_MASK, 32'h0000_0010);
        // The new mask reaches the registered interrupt one edge after the write lands.
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'b1)
        apb(0, `LCS_ADDR_IRQ_STATUS, 32'h0000_0000);
        `CHK(rd[4], 1'b1)
        level_floating <= 1'b1;
        wait_obs(3, 1, 20);
        status(32'h0000_0100);
        level_floating <= 1'b0;
        wait_obs(0, 1, 20);
        apb(1, `LCS_ADDR_CTRL, 32'h0000_0001);
        wait_obs(3, 1, 20);
        $display("Restart and suspend done");
        // From here the select pin asks for the second current setting.
        level_high <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            vin_ok <= 1'b0;
            wait_obs(3, 1, 20);
            apb(1, `LCS_ADDR_CTRL, 32'(i) << 1);
            {dead, cell_reset, vin_ok} <= 3'h7;
            @(posedge core_clk);
            cell_reset <= 1'b0;
            wait_obs(0, 1, 20);
            t0 = cyc;
            `CHK(current_cmd, 10'h03C)
            wait_obs(0, 0, 3000);
            `CHK(cyc - t0 > (mins[i] - 1) * MIN && cyc - t0 <= mins[i] * MIN + 8, 1'b1)
            status(32'h0000_0202);
            repeat (40) @(posedge core_clk);
            status(32'h0000_0202);
        end
        $display("Safety timer done");
        vin_ok <= 1'b0;
        wait_obs(3, 1, 20);
        apb(1, `LCS_ADDR_CTRL, 32'h0000_0016);
        vin_ok <= 1'b1;
        wait_obs(0, 1, 20);
        `CHK(current_cmd, 10'h02D)
        status(32'h0000_0011);
        repeat (2500) @(posedge core_clk);
        `CHK(charge_enable, 1'b1)
        dead <= 1'b0;
        wait_obs(1, 1, 40);
        `CHK(current_cmd, 10'h05A)
        // Reset in mid-charge isolates the cell at once and restores the registers.
        reset <= 1'b1;
        @(posedge core_clk);
        `CHK(obs, 4'h8)
        reset <= 1'b0;
        wait_obs(0, 1, 20);
        apb(0, `LCS_ADDR_CTRL, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        vin_ok <= 1'b0;
        wait_obs(3, 1, 8);
        status(32'h0000_0100);
        $display("Timer off and supply loss done");
        final_report();
    end
endmodule // li_ion_charge_state_machine_tb_top
bind lcs_charger lcs_chk u_chk (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .supply_valid(supply_valid), .charge_enable(charge_enable),
    .cc_mode(cc_mode), .cv_mode(cv_mode), .battery_hiz(battery_hiz), .current_cmd(current_cmd),
    .charge_indicator_output_o(charge_indicator_output_o),
    .charge_indicator_output_oe_n(charge_indicator_output_oe_n));
